// [hdl/dcr_params.svh]
`ifndef DCR_PARAMS_SVH
`define DCR_PARAMS_SVH
// Register byte offsets
`define DCR_CTRL_OFS      8'h00
`define DCR_GAIN_OFS      8'h04
`define DCR_STAT_OFS      8'h08
// Control field positions
`define DCR_B_SRSTN       0
`define DCR_B_ZDEN        1
`define DCR_B_ZCMB        2
`define DCR_B_ZPOL        3
`define DCR_B_SWAP        4
`define DCR_B_MONO        5
`define DCR_B_LINV        6
`define DCR_B_RINV        7
`define DCR_B_DSD         8
`define DCR_B_EXTF        9
`define DCR_B_D512        10
`define DCR_B_BYP         11
`define DCR_B_DSD_FILTER_CUTOFF_SEL        12
`define DCR_CTRL_W        13
// Reset values
`define DCR_CTRL_RST      13'h0003
`define DCR_GAIN_RST      3'h0
// Timing in sample periods (fsb)
`define DCR_ZD_PERIODS    8192
`define DCR_ZD512_PERIODS 16384
`define DCR_REL_PERIODS   4
`endif

// [hdl/dcr_pkg.sv]
`default_nettype none
package dcr_pkg;
   // One-hot output level selection
   typedef enum logic [2:0] {
      DCR_LVL_2P5  = 3'h1,
      DCR_LVL_2P8  = 3'h2,
      DCR_LVL_3P75 = 3'h4
   } dcr_lvl_e;
   // Per-channel zero detector state
   typedef enum logic [2:0] {
      DCR_ZS_HOLD = 3'h1,
      DCR_ZS_WAIT = 3'h2,
      DCR_ZS_RUN  = 3'h4
   } dcr_zst_e;
endpackage : dcr_pkg
`default_nettype wire

// [hdl/dcr_top.sv]
// The implementer's own choices: the APB interface to the registers and the register offsets.
`default_nettype none
`include "dcr_params.svh"
// Behaviour
// - Register mode PCM: codes 000/001 give 2.8, 100/101 give 3.75, else 2.5 Vpp
// - DSD normal path: 000 gives 2.8, 100 gives 3.75, else 2.5; bypass always 2.5
// - Pin mode PCM: gain pin low gives 2.8 Vpp, high gives 3.75 Vpp
// - External-filter mode uses the same gain mapping as PCM
// - Channel zero flag rises after 8192 consecutive zero sample periods
// - DSD512 rate needs 16384 consecutive zero sample periods instead
// - Nonzero data drops a raised zero flag at once
// - Soft reset holds both flags high; low 4 periods after first one bit
// - Combine bit set: both flags high only when both channels detect zero
// - Zero detect enable clear: both flags held low, or high when the polarity bit is set
// - DSD volume bypass disables zero detection
// - Polarity bit inverts both flags; bit 0 means high on zero
// - Stereo: swap 0 passes straight, swap 1 crosses channels
// - Mono: both outputs from left when swap 0, from right when 1
// - Per-channel invert bits applied after channel selection
// - Selection behaves the same in PCM, DSD, external filter; inversion negates PCM and ext-filter samples, flips bit 0 in DSD
// - Pin mode: straight routing, right inverted by right invert pin
// - Bypass bit 1 selects DSD volume bypass, 0 the default normal path
module dcr_top
   import dcr_pkg::*;
#(
   parameter int DW          = 32,
   parameter int ZD_PERIODS  = `DCR_ZD_PERIODS,
   parameter int ZD5_PERIODS = `DCR_ZD512_PERIODS
) (
   // Clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // Pin-control mode
   input  wire logic          pin_mode,
   input  wire logic          gain_pin,
   input  wire logic          right_invert_pin,
   // Sample input, one strobe per sample period
   input  wire logic          in_valid,
   input  wire logic [DW-1:0] left_in,
   input  wire logic [DW-1:0] right_in,
   // Conditioned output
   output logic               out_valid,
   output logic [DW-1:0]      left_out,
   output logic [DW-1:0]      right_out,
   // Level selection and flags
   output dcr_lvl_e           level_sel,
   output logic               left_zero_flag_out,
   output logic               right_zero_flag_out
);
   localparam int CW = 15;
   localparam logic [CW-1:0] THR  = CW'(ZD_PERIODS);
   localparam logic [CW-1:0] THR5 = CW'(ZD5_PERIODS);
   localparam logic [2:0]    RELN = 3'(`DCR_REL_PERIODS - 1);

   // Register state
   logic [`DCR_CTRL_W-1:0] ctrl;
   logic [`DCR_CTRL_W-1:0] next_ctrl;
   logic [2:0]             output_gain_code;
   logic [2:0]             next_gain;
   logic [31:0]            next_prdata;
   logic                   next_pslverr;

   logic soft_reset_n;
   logic zero_detect_enable;
   logic zero_flag_combine;
   logic zero_flag_polarity;
   logic channel_swap_select;
   logic mono_sel;
   logic left_phase_invert;
   logic right_phase_invert;
   logic dsd_mode;
   logic external_filter_mode;
   logic dsd512_mode;
   logic dsd_volume_bypass;
   logic dsd_filter_cutoff_sel;

   assign soft_reset_n          = ctrl[`DCR_B_SRSTN];
   assign zero_detect_enable    = ctrl[`DCR_B_ZDEN];
   assign zero_flag_combine     = ctrl[`DCR_B_ZCMB];
   assign zero_flag_polarity    = ctrl[`DCR_B_ZPOL];
   assign channel_swap_select   = ctrl[`DCR_B_SWAP];
   assign mono_sel              = ctrl[`DCR_B_MONO];
   assign left_phase_invert     = ctrl[`DCR_B_LINV];
   assign right_phase_invert    = ctrl[`DCR_B_RINV];
   assign dsd_mode              = ctrl[`DCR_B_DSD];
   assign external_filter_mode  = ctrl[`DCR_B_EXTF];
   assign dsd512_mode           = ctrl[`DCR_B_D512];
   assign dsd_volume_bypass     = ctrl[`DCR_B_BYP];
   // Stored only; host keeps it 0 for code 100 on the DSD normal path
   assign dsd_filter_cutoff_sel = ctrl[`DCR_B_DSD_FILTER_CUTOFF_SEL];

   // Zero detector shared signals
   logic [1:0]          raw_zero;
   logic [1:0]          next_flags;
   logic [1:0]          flags;
   logic [DW-1:0]       ch_in [2];

   assign ch_in[0] = left_in;
   assign ch_in[1] = right_in;

   // APB: read data captured in setup so the access phase is zero-wait
   assign pready = 1'b1;

   always_comb begin
      logic wr;
      logic hit;
      wr           = psel & penable & pwrite;
      hit          = (paddr == `DCR_CTRL_OFS) | (paddr == `DCR_GAIN_OFS)
                   | (paddr == `DCR_STAT_OFS);
      next_ctrl    = ctrl;
      next_gain    = output_gain_code;
      next_prdata  = prdata;
      next_pslverr = pslverr;
      if (psel & ~penable) begin
         next_pslverr = ~hit;
         case (paddr)
            `DCR_CTRL_OFS: next_prdata = 32'(ctrl);
            `DCR_GAIN_OFS: next_prdata = 32'(output_gain_code);
            `DCR_STAT_OFS: next_prdata = {27'h0, level_sel, flags};
            default:       next_prdata = 32'h0;
         endcase
      end
      if (wr) begin
         case (paddr)
            `DCR_CTRL_OFS: next_ctrl = pwdata[`DCR_CTRL_W-1:0];
            `DCR_GAIN_OFS: next_gain = pwdata[2:0];
            default:       next_ctrl = ctrl;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl             <= `DCR_CTRL_RST;
         output_gain_code <= `DCR_GAIN_RST;
         prdata           <= 32'h0;
         pslverr          <= 1'b0;
      end else begin
         ctrl             <= next_ctrl;
         output_gain_code <= next_gain;
         prdata           <= next_prdata;
         pslverr          <= next_pslverr;
      end
   end

   // Output level decode
   dcr_lvl_e next_level;

   always_comb begin
      next_level = DCR_LVL_2P5;
      if (pin_mode && !dsd_mode) begin
         next_level = gain_pin ? DCR_LVL_3P75 : DCR_LVL_2P8;
      end else if (dsd_mode && dsd_volume_bypass) begin
         next_level = DCR_LVL_2P5;
      end else if (dsd_mode) begin
         case (output_gain_code)
            3'h0:    next_level = DCR_LVL_2P8;
            3'h4:    next_level = DCR_LVL_3P75;
            default: next_level = DCR_LVL_2P5;
         endcase
      end else begin
         // External filter shares the PCM mapping
         case (output_gain_code)
            3'h0, 3'h1: next_level = DCR_LVL_2P8;
            3'h4, 3'h5: next_level = DCR_LVL_3P75;
            default:    next_level = DCR_LVL_2P5;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_sel <= DCR_LVL_2P8;
      end else begin
         level_sel <= next_level;
      end
   end

   // Per-channel zero detectors
   for (genvar i = 0; i < 2; i++) begin : g_zd
      dcr_zst_e      zst;
      dcr_zst_e      next_zst;
      logic [CW-1:0] cnt;
      logic [CW-1:0] next_cnt;
      logic [2:0]    rel;
      logic [2:0]    next_rel;
      logic          nz;
      logic [CW-1:0] thr;

      assign nz  = dsd_mode ? ch_in[i][0] : |ch_in[i];
      assign thr = dsd512_mode ? THR5 : THR;

      always_comb begin
         next_zst = zst;
         next_cnt = cnt;
         next_rel = rel;
         if (!soft_reset_n) begin
            next_zst = DCR_ZS_HOLD;
            next_cnt = '0;
            next_rel = '0;
         end else begin
            case (zst)
               DCR_ZS_HOLD: begin
                  if (in_valid && nz) begin
                     next_zst = DCR_ZS_WAIT;
                     next_rel = '0;
                  end
               end
               DCR_ZS_WAIT: begin
                  if (in_valid) begin
                     next_rel = rel + 3'h1;
                     if (rel == RELN) begin
                        next_zst = DCR_ZS_RUN;
                     end
                  end
               end
               DCR_ZS_RUN: begin
                  if (in_valid) begin
                     if (nz) begin
                        next_cnt = '0;
                     end else if (cnt < thr) begin
                        next_cnt = cnt + CW'(1);
                     end
                  end
               end
               default: next_zst = DCR_ZS_HOLD;
            endcase
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            zst <= DCR_ZS_HOLD;
            cnt <= '0;
            rel <= '0;
         end else begin
            zst <= next_zst;
            cnt <= next_cnt;
            rel <= next_rel;
         end
      end

      // Nonzero sample masks the flag in the same cycle it arrives
      assign raw_zero[i] = (zst != DCR_ZS_RUN)
                         | ((cnt >= thr) & ~(in_valid & nz));
   end : g_zd

   // Flag combine, enable and polarity
   always_comb begin
      logic both;
      logic en;
      both = &raw_zero;
      en   = zero_detect_enable & ~(dsd_mode & dsd_volume_bypass);
      if (!en) begin
         next_flags = 2'h0;
      end else if (zero_flag_combine) begin
         next_flags = {both, both};
      end else begin
         next_flags = raw_zero;
      end
      next_flags = next_flags ^ {2{zero_flag_polarity}};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= 2'h0;
      end else begin
         flags <= next_flags;
      end
   end

   assign left_zero_flag_out  = flags[0];
   assign right_zero_flag_out = flags[1];

   // Channel routing and phase inversion
   logic [DW-1:0] next_left;
   logic [DW-1:0] next_right;

   function automatic logic [DW-1:0] dcr_inv(input logic [DW-1:0] d, input logic dsd);
      // Negating full-scale negative wraps; same as two's complement hardware
      if (dsd) begin
         return {{(DW-1){1'b0}}, ~d[0]};
      end
      return DW'(-d);
   endfunction : dcr_inv

   always_comb begin
      logic [DW-1:0] sl;
      logic [DW-1:0] sr;
      logic          il;
      logic          ir;
      // Register mode routing first; mono and pin mode override
      sl = channel_swap_select ? right_in : left_in;
      sr = channel_swap_select ? left_in : right_in;
      il = left_phase_invert;
      ir = right_phase_invert;
      if (pin_mode) begin
         sl = left_in;
         sr = right_in;
         il = 1'b0;
         ir = right_invert_pin;
      end else if (mono_sel) begin
         sr = sl;
      end
      next_left  = il ? dcr_inv(sl, dsd_mode) : sl;
      next_right = ir ? dcr_inv(sr, dsd_mode) : sr;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_out  <= '0;
         right_out <= '0;
         out_valid <= 1'b0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            left_out  <= next_left;
            right_out <= next_right;
         end
      end
   end

endmodule : dcr_top
`default_nettype wire

// [sim/dcr_src.sv]
`default_nettype none
module dcr_src #(
   parameter int DW = 32
) (
   // Control from bench
   input wire logic          pclk,
   input wire logic          run,
   input wire logic          fast,
   input wire logic [1:0]    zero,
   // Sample stream
   output var logic          in_valid,
   output var logic [DW-1:0] left_in,
   output var logic [DW-1:0] right_in
);
   timeunit 1ns;
   timeprecision 1ns;
   int         seed = 74;
   logic [1:0] gap = 2'h0;
   initial begin
      in_valid = 1'b0;
      left_in = '0;
      right_in = '0;
   end
   always @(posedge pclk) begin
      gap <= gap + 2'h1;
      in_valid <= run && (fast || gap == 2'h3);
      if (run && (fast || gap == 2'h3)) begin
         // Odd values stay nonzero in one-bit mode too
         left_in <= zero[0] ? '0 : DW'($random(seed) | 1);
         right_in <= zero[1] ? '0 : DW'($random(seed) | 1);
      end else begin
         // Idle lines flip so a stale sample never passes
         left_in <= ~left_in;
         right_in <= ~right_in;
      end
   end
endmodule : dcr_src
`default_nettype wire

// [sim/dcr_top_properties.sv]
`default_nettype none
`include "dcr_params.svh"
module dcr_chk
   import dcr_pkg::*;
#(
   parameter int DW = 32
) (
   // Clock, reset and bus
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [7:0]    paddr,
   input wire logic [31:0]   pwdata,
   // Pins, samples and flags
   input wire logic          pin_mode,
   input wire logic          right_invert_pin,
   input wire logic          in_valid,
   input wire logic [DW-1:0] left_in,
   input wire logic [DW-1:0] right_in,
   input wire logic [DW-1:0] left_out,
   input wire logic [DW-1:0] right_out,
   input wire dcr_lvl_e      level_sel,
   input wire logic          left_zero_flag_out,
   input wire logic          right_zero_flag_out
);
   logic [12:0] cm;
   wire logic   zl = left_zero_flag_out;
   wire logic   zr = right_zero_flag_out;
   // Control mirror rebuilt from bus writes; ports are all we see
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cm <= `DCR_CTRL_RST;
      else if (psel && penable && pwrite && paddr == `DCR_CTRL_OFS)
         cm <= pwdata[12:0];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_disable_low: assert property ((!cm[1] && !cm[3]) [*2] |-> !zl && !zr)
      else $error("flags not low while disabled");
   a_soft_hold: assert property ((!cm[0] && cm[1] && !cm[3] && !cm[11]) [*3] |-> zl && zr)
      else $error("flags not high in soft reset");
   a_combine_same: assert property (cm[2] [*2] |-> zl == zr)
      else $error("combined flags differ");
   a_bypass_quiet: assert property ((cm[8] && cm[11] && !cm[3]) [*2] |-> !zl && !zr)
      else $error("flag raised in bypass");
   a_bypass_level: assert property ((!pin_mode && cm[8] && cm[11]) [*2] |-> level_sel == DCR_LVL_2P5)
      else $error("bypass level wrong");
   a_swap_route: assert property (in_valid && !pin_mode && cm[8:4] == 5'h01
      |=> left_out == $past(right_in) && right_out == $past(left_in))
      else $error("swap routing wrong");
   a_mono_invert: assert property (in_valid && !pin_mode && cm[8:4] == 5'h0B
      |=> left_out == $past(right_in) && right_out == -$past(right_in))
      else $error("mono invert wrong");
   a_pin_route: assert property (in_valid && pin_mode && !cm[8] |=> left_out == $past(left_in)
      && right_out == ($past(right_invert_pin) ? -$past(right_in) : $past(right_in)))
      else $error("pin routing wrong");
endmodule : dcr_chk
bind dcr_top dcr_chk #(.DW(DW)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pin_mode, .right_invert_pin, .in_valid, .left_in, .right_in, .left_out,
   .right_out, .level_sel, .left_zero_flag_out, .right_zero_flag_out);
`default_nettype wire

// [sim/test_dcr_top.sv]
`default_nettype none
`include "dcr_params.svh"
module test_dcr_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic         pin_mode = 1'b0, gain_pin = 1'b0, right_invert_pin = 1'b0;
   logic         run = 1'b0, fast = 1'b0, err, pready, pslverr, in_valid, out_valid, lz, rz;
   logic [1:0]   zero = 2'h0;
   logic [2:0]   lvl;
   logic [7:0]   paddr = 8'h0;
   logic [12:0]  c = 13'h0003;
   logic [12:0]  md[4] = '{13'h003, 13'h103, 13'h903, 13'h203};
   logic [31:0]  pwdata = 32'h0, prdata, q, left_in, right_in, left_out, right_out;
   logic [127:0] n;
   logic [127:0] nq[$];
   int           failures = 0, checked = 0, cyc = 0;
   always #10 pclk = ~pclk;
   dcr_src src (.pclk, .run, .fast, .zero, .in_valid, .left_in, .right_in);
   dcr_top #(.ZD_PERIODS(16), .ZD5_PERIODS(32)) dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_mode, .gain_pin,
      .right_invert_pin, .in_valid, .left_in, .right_in, .out_valid, .left_out,
      .right_out, .level_sel(lvl), .left_zero_flag_out(lz), .right_zero_flag_out(rz));
   function automatic logic [127:0] route(logic [12:0] k, logic pm, logic ri,
                                          logic [31:0] l, logic [31:0] r);
      logic [31:0] a, b;
      a = (k[4] && !pm) ? r : l;
      b = ((k[5] ^ k[4]) && !pm) ? l : r;
      if (k[6] && !pm) a = k[8] ? ~a : -a;
      if (pm ? ri : k[7]) b = k[8] ? ~b : -b;
      // Soft reset state leaves samples unchecked
      return {a, b, {2{k[8] ? 32'h1 : 32'hFFFFFFFF}} & {64{k[0]}}};
   endfunction : route
   function automatic logic [2:0] lv(logic [12:0] k, logic [2:0] g);
      if (k[8] && k[11]) return 3'h1;
      if (k[8]) return g == 3'h0 ? 3'h2 : (g == 3'h4 ? 3'h4 : 3'h1);
      return g[2:1] == 2'h0 ? 3'h2 : (g[2:1] == 2'h2 ? 3'h4 : 3'h1);
   endfunction : lv
   task automatic chk(logic [63:0] g, logic [63:0] e);
      checked++;
      if (g !== e) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      if (w && a == `DCR_CTRL_OFS) c <= d[12:0];
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(logic [7:0] a, logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rd
   task automatic wr(logic [7:0] a, logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic tk(int k);
      repeat (k) @(posedge pclk iff in_valid === 1'b1);
      @(posedge pclk);
      @(negedge pclk);
   endtask : tk
   task automatic fl(logic [1:0] e);
      chk({rz, lz}, e);
   endtask : fl
   task automatic sz(logic [1:0] z);
      @(posedge pclk iff in_valid === 1'b1);
      zero <= z;
   endtask : sz
   task automatic tally_and_finish;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge pclk) begin
      if (in_valid === 1'b1) nq.push_back(route(c, pin_mode, right_invert_pin, left_in, right_in));
      if (out_valid === 1'b1 && nq.size() > 0) begin
         n = nq.pop_front();
         chk({left_out, right_out} & n[63:0], n[127:64] & n[63:0]);
      end
      cyc++;
      if (cyc == 20000) begin
         failures++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(`DCR_CTRL_OFS, 32'h3);
      rd(`DCR_GAIN_OFS, 32'h0);
      rd(`DCR_STAT_OFS, 32'h0000000B);
      chk(err, 1'b0);
      rd(8'h0C, 32'h0);
      chk(err, 1'b1);
      $display("test registers done");
      run <= 1'b1;
      tk(3);
      fl(2'h3);
      tk(3);
      fl(2'h0);
      sz(2'h1);
      tk(15);
      fl(2'h0);
      tk(1);
      fl(2'h1);
      wr(`DCR_CTRL_OFS, 32'h7);
      tk(1);
      fl(2'h0);
      sz(2'h3);
      tk(16);
      fl(2'h3);
      wr(`DCR_CTRL_OFS, 32'hB);
      tk(1);
      fl(2'h0);
      wr(`DCR_CTRL_OFS, 32'h3);
      sz(2'h0);
      tk(1);
      fl(2'h0);
      wr(`DCR_CTRL_OFS, 32'h503);
      sz(2'h3);
      tk(31);
      fl(2'h0);
      tk(1);
      fl(2'h3);
      wr(`DCR_CTRL_OFS, 32'h903);
      tk(1);
      fl(2'h0);
      wr(`DCR_CTRL_OFS, 32'h2);
      tk(1);
      fl(2'h3);
      wr(`DCR_CTRL_OFS, 32'h0);
      tk(1);
      fl(2'h0);
      sz(2'h0);
      $display("test zero detect done");
      for (int m = 0; m < 4; m++) begin
         wr(`DCR_CTRL_OFS, {19'h0, md[m]});
         for (int g = 0; g < 8; g++) begin
            wr(`DCR_GAIN_OFS, g);
            rd(`DCR_GAIN_OFS, g);
            chk(lvl, lv(c, g[2:0]));
         end
      end
      wr(`DCR_CTRL_OFS, 32'h3);
      pin_mode <= 1'b1;
      for (int g = 0; g < 2; g++) begin
         gain_pin <= g[0];
         repeat (3) @(posedge pclk);
         chk(lvl, g ? 3'h4 : 3'h2);
      end
      $display("test gain done");
      for (int i = 0; i < 34; i++) begin
         right_invert_pin <= i[0];
         pin_mode <= i > 31;
         fast <= i[1];
         wr(`DCR_CTRL_OFS, {23'h0, i[4], i[3:0], 4'h3});
         repeat (12) @(posedge pclk);
      end
      $display("test routing done");
      tally_and_finish();
   end
endmodule : test_dcr_top
`default_nettype wire
